// ==== shared/clkgen_map.svh ====
// constants for the clock generator: register map, reset values, timing
// assumes inclusion by bare name from the loop filter, core and bench files
// Notes on behaviour
// - bus clock is a quarter of oscillator clock, half of generator clock.
// - stop mode with run-in-stop clear asserts generator stop, halting all clocks.
// - run-in-stop set keeps generator clocks running during stop mode.
// - internal enable is internal-on and not stop; else internal and base low.
// - external enable is external-on and not stop; else external clock low.
// - external-on bit cannot be set unless external clock is allowed.
// - pin one port enable low while external-on set, regardless of stop.
// - pin two port enable low while external-on and crystal enable set.
// - internal clock is N times base clock, N from multiplier register.
// - divider divides internal clock by N; N of one or zero passes through.
// - control word is 4-bit divider field above 8-bit stage field, 0 to FFF.
// - each comparison adds or subtracts by error band, exact match holds; subtracting raises frequency.
// - step 1 within 5%, 8 within 15%, else 32; slow subtracts.
// - divider field A to F acts as 9; subtraction continues back into range.
// - divider field moves only on carry or borrow out of stage field.
// - filter-stable flag set while base error is at most five percent.
// - timebase clock comes from external clock whenever the external-on bit is set.
`ifndef CLKGEN_MAP_SVH
`define CLKGEN_MAP_SVH
`define ADDR_CTRL       4'h0
`define ADDR_MULT       4'h1
`define ADDR_STATUS     4'h2
`define ADDR_WORD_LO    4'h3
`define ADDR_WORD_HI    4'h4
`define CTRL_INT_ON     0
`define CTRL_EXT_ON     1
`define CTRL_RESET      2'h1
`define MULT_RESET      7'h04
`define WORD_RESET      12'h0400
`define WORD_MAX        12'h09FF
`define WORD_TOP        12'h0FFF
`define DIV_SLOWEST     4'h9
`define DCO_SPAN        16'h1000
`define STEP_SMALL      12'h0001
`define STEP_MID        12'h0008
`define STEP_BIG        12'h0020
`define SYS_CLK_HZ      25000000
`define NOM_FREQ_HZ     307200
`define PCT_FULL        100
`define PCT_085         85
`define PCT_095         95
`define PCT_105         105
`define PCT_115         115
`endif

// ==== shared/clkgen_pkg.sv ====
// types shared by the clock generator files
// assumes nothing beyond a SystemVerilog compiler
package clkgen_pkg;
	typedef logic [11:0] word_t;
	typedef logic [6:0]  mult_t;
	typedef enum logic [2:0] {
		BAND_SLOW_BIG,
		BAND_SLOW_MID,
		BAND_SLOW_SMALL,
		BAND_EXACT,
		BAND_FAST_SMALL,
		BAND_FAST_MID,
		BAND_FAST_BIG
	} band_e;
endpackage

// ==== logic/mod_divider.sv ====
// modulo-n divider making the base clock from the internal clock
// assumes internal clock is a level sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module mod_divider
	import clkgen_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic        i_enable,
	input  wire logic        i_internal_clock,
	input  wire clkgen_pkg::mult_t i_mult,
	output logic             o_base_clock
);
	logic  int_prev_reg;
	mult_t count_reg;
	logic  int_rise;

	assign int_rise = i_internal_clock & ~int_prev_reg;

	// count internal clock rises, wrap at n, high for the first half
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			int_prev_reg <= 1'b0;
			count_reg    <= '0;
			o_base_clock <= 1'b0;
		end
		else if (!i_enable)
		begin
			int_prev_reg <= 1'b0;
			count_reg    <= '0;
			o_base_clock <= 1'b0;
		end
		else
		begin
			int_prev_reg <= i_internal_clock;
			if (i_mult <= mult_t'(1))
				o_base_clock <= i_internal_clock;
			else
			begin
				if (int_rise)
					count_reg <= (count_reg >= i_mult - mult_t'(1)) ? '0 : count_reg + mult_t'(1);
				o_base_clock <= (count_reg < (i_mult >> 1));
			end
		end
	end
endmodule
`default_nettype wire

// ==== logic/loop_filter.sv ====
// loop filter: measures base clock period, corrects the oscillator word
// assumes base rise is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_map.svh"
module loop_filter
	import clkgen_pkg::*;
#(
	parameter int NOM_CYCLES = `SYS_CLK_HZ / `NOM_FREQ_HZ
)(
	input  wire logic  i_sys_clk,
	input  wire logic  i_rst,
	input  wire logic  i_enable,
	input  wire logic  i_base_rise,
	output clkgen_pkg::word_t o_word,
	output logic       o_stable
);
	logic [15:0] period_reg;
	logic        primed_reg;
	logic [31:0] nom_x;
	logic [31:0] per;
	band_e       band;

	assign nom_x = 32'(`PCT_FULL * NOM_CYCLES);
	assign per   = {16'h0000, period_reg};

	// longer period means slower base clock
	always_comb
	begin
		if (nom_x < per * 32'(`PCT_085))
			band = BAND_SLOW_BIG;
		else if (nom_x < per * 32'(`PCT_095))
			band = BAND_SLOW_MID;
		else if (nom_x < per * 32'(`PCT_FULL))
			band = BAND_SLOW_SMALL;
		else if (nom_x == per * 32'(`PCT_FULL))
			band = BAND_EXACT;
		else if (nom_x <= per * 32'(`PCT_105))
			band = BAND_FAST_SMALL;
		else if (nom_x <= per * 32'(`PCT_115))
			band = BAND_FAST_MID;
		else
			band = BAND_FAST_BIG;
	end

	// period counter, restarted at each base rise
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			period_reg <= '0;
			primed_reg <= 1'b0;
		end
		else if (!i_enable)
		begin
			period_reg <= '0;
			primed_reg <= 1'b0; // first period after enable is partial
		end
		else if (i_base_rise)
		begin
			period_reg <= 16'h0001;
			primed_reg <= 1'b1;
		end
		else if (period_reg != 16'hFFFF)
			period_reg <= period_reg + 16'h0001;
	end

	// one correction per completed comparison; div moves only by carry or borrow
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_word   <= `WORD_RESET;
			o_stable <= 1'b0;
		end
		else if (!i_enable)
			o_stable <= 1'b0;
		else if (i_base_rise && primed_reg)
		begin
			o_stable <= (band == BAND_SLOW_SMALL) || (band == BAND_EXACT) || (band == BAND_FAST_SMALL);
			unique case (band)
				BAND_SLOW_BIG:   o_word <= o_word - `STEP_BIG;
				BAND_SLOW_MID:   o_word <= o_word - `STEP_MID;
				BAND_SLOW_SMALL: o_word <= o_word - `STEP_SMALL;
				BAND_EXACT:      o_word <= o_word;
				BAND_FAST_SMALL: o_word <= (o_word > `WORD_TOP - `STEP_SMALL) ? `WORD_TOP : o_word + `STEP_SMALL;
				BAND_FAST_MID:   o_word <= (o_word > `WORD_TOP - `STEP_MID) ? `WORD_TOP : o_word + `STEP_MID;
				BAND_FAST_BIG:   o_word <= (o_word > `WORD_TOP - `STEP_BIG) ? `WORD_TOP : o_word + `STEP_BIG;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== logic/clock_generator_unit.sv ====
// clock generator core: enables, oscillator model, divider, loop filter,
// output clock chain and a small register port
// assumes one system clock; configuration bits and stop mode are levels
// from the integration unit, synchronous to the system clock
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_map.svh"
module clock_generator_unit
	import clkgen_pkg::*;
#(
	parameter int NOM_CYCLES = `SYS_CLK_HZ / `NOM_FREQ_HZ
)(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_stop_mode,
	input  wire logic       i_osc_run_in_stop_cfg,
	input  wire logic       i_external_allowed_cfg,
	input  wire logic       i_crystal_enable_cfg,
	input  wire logic       i_osc_pin_one,
	output logic            o_osc_pin1_port_enable,
	output logic            o_osc_pin2_port_enable,
	output logic            o_generator_stop,
	output logic            o_internal_gen_enable,
	output logic            o_external_gen_enable,
	output logic            o_internal_clock,
	output logic            o_external_clock,
	output logic            o_base_clock,
	output logic            o_osc_output_clock,
	output logic            o_gen_output_clock,
	output logic            o_bus_clock,
	output logic            o_timebase_clock,
	output logic            o_filter_stable_flag
);
	// software control state
	logic        internal_on_bit;
	logic        external_on_bit;
	mult_t       multiplier_register;

	// enable chain, combinational next values of the enable flops
	logic        generator_stop_next;
	logic        internal_gen_enable_next;
	logic        external_gen_enable_next;

	// oscillator model
	word_t       osc_word;
	logic [3:0]  osc_divider_field;
	logic [7:0]  osc_stage_field;
	logic [3:0]  div_effective;
	word_t       word_effective;
	logic [15:0] dco_acc_reg;
	logic [15:0] dco_step;

	// divider and filter
	logic        base_clock_w;
	logic        base_prev_reg;
	logic        base_rise;
	logic        filter_stable_w;

	// output chain
	logic        osc_src;
	logic        osc_prev_reg;
	logic        gen_prev_reg;
	logic        osc_rise;
	logic        gen_rise;
	logic [7:0]  status_byte;

	// reset value of the control bits, indexed per bit
	localparam logic [1:0] CTRL_RST = `CTRL_RESET;

	// control register: internal-on and external-on bits
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			internal_on_bit <= CTRL_RST[`CTRL_INT_ON];
			external_on_bit <= CTRL_RST[`CTRL_EXT_ON];
		end
		else if (i_wr && (i_addr == `ADDR_CTRL))
		begin
			internal_on_bit <= i_wdata[`CTRL_INT_ON];
			// a set is only taken while the external source is allowed
			external_on_bit <= i_wdata[`CTRL_EXT_ON] & i_external_allowed_cfg;
		end
	end

	// multiplier register, n factor of the internal clock
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			multiplier_register <= `MULT_RESET;
		else if (i_wr && (i_addr == `ADDR_MULT))
			multiplier_register <= i_wdata[6:0];
	end

	// enable logic; stop only bites when run-in-stop is clear
	always_comb
	begin
		generator_stop_next      = i_stop_mode & ~i_osc_run_in_stop_cfg;
		internal_gen_enable_next = internal_on_bit & ~generator_stop_next;
		external_gen_enable_next = external_on_bit & ~generator_stop_next;
	end

	// enable flops, also the module outputs
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_generator_stop      <= 1'b0;
			o_internal_gen_enable <= 1'b0;
			o_external_gen_enable <= 1'b0;
		end
		else
		begin
			o_generator_stop      <= generator_stop_next;
			o_internal_gen_enable <= internal_gen_enable_next;
			o_external_gen_enable <= external_gen_enable_next;
		end
	end

	// shared pin port enables; deliberately not gated by stop
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_osc_pin1_port_enable <= 1'b1;
			o_osc_pin2_port_enable <= 1'b1;
		end
		else
		begin
			o_osc_pin1_port_enable <= ~external_on_bit;
			o_osc_pin2_port_enable <= ~(external_on_bit & i_crystal_enable_cfg);
		end
	end

	// external input path; low from the cycle after its enable goes low
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			o_external_clock <= 1'b0;
		else
			o_external_clock <= i_osc_pin_one & o_external_gen_enable;
	end

	// split word and clamp out-of-range divider field to the slowest
	always_comb
	begin
		osc_divider_field = osc_word[11:8];
		osc_stage_field   = osc_word[7:0];
		div_effective     = (osc_divider_field > `DIV_SLOWEST) ? `DIV_SLOWEST : osc_divider_field;
		word_effective    = {div_effective, osc_stage_field};
		dco_step          = `DCO_SPAN - {4'h0, word_effective}; // larger word, slower clock
	end

	// phase accumulator standing in for the ring oscillator
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			dco_acc_reg      <= '0;
			o_internal_clock <= 1'b0;
		end
		else if (!o_internal_gen_enable)
		begin
			dco_acc_reg      <= '0;
			o_internal_clock <= 1'b0;
		end
		else
		begin
			dco_acc_reg      <= dco_acc_reg + dco_step;
			o_internal_clock <= dco_acc_reg[15];
		end
	end

	// modulo-n divider
	mod_divider u_mod_divider (
		.i_sys_clk        (i_sys_clk),
		.i_rst            (i_rst),
		.i_enable         (o_internal_gen_enable),
		.i_internal_clock (o_internal_clock),
		.i_mult           (multiplier_register),
		.o_base_clock     (base_clock_w)
	);

	// base clock output and rise detect feeding the comparator
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			base_prev_reg <= 1'b0;
			o_base_clock  <= 1'b0;
		end
		else
		begin
			base_prev_reg <= base_clock_w;
			o_base_clock  <= base_clock_w & o_internal_gen_enable;
		end
	end

	assign base_rise = base_clock_w & ~base_prev_reg;

	// frequency comparison and word correction
	loop_filter #(
		.NOM_CYCLES (NOM_CYCLES)
	) u_loop_filter (
		.i_sys_clk   (i_sys_clk),
		.i_rst       (i_rst),
		.i_enable    (o_internal_gen_enable),
		.i_base_rise (base_rise),
		.o_word      (osc_word),
		.o_stable    (filter_stable_w)
	);

	// stable flag toward the clock monitor
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			o_filter_stable_flag <= 1'b0;
		else
			o_filter_stable_flag <= filter_stable_w;
	end

	// oscillator clock source: external when wanted and running
	assign osc_src = o_external_gen_enable ? o_external_clock : o_internal_clock;

	// oscillator output and timebase clocks
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_osc_output_clock <= 1'b0;
			o_timebase_clock   <= 1'b0;
		end
		else
		begin
			o_osc_output_clock <= osc_src;
			// external-on picks the external clock even before it settles
			o_timebase_clock   <= external_on_bit ? o_external_clock : o_internal_clock;
		end
	end

	assign osc_rise = o_osc_output_clock & ~osc_prev_reg;
	assign gen_rise = o_gen_output_clock & ~gen_prev_reg;

	// divide-by-two stages: generator clock, then bus clock
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			osc_prev_reg       <= 1'b0;
			gen_prev_reg       <= 1'b0;
			o_gen_output_clock <= 1'b0;
			o_bus_clock        <= 1'b0;
		end
		else
		begin
			osc_prev_reg <= o_osc_output_clock;
			gen_prev_reg <= o_gen_output_clock;
			if (osc_rise)
				o_gen_output_clock <= ~o_gen_output_clock;
			if (gen_rise)
				o_bus_clock <= ~o_bus_clock;
		end
	end

	// status byte: enables, stop and filter state
	assign status_byte = {4'h0, o_generator_stop, o_filter_stable_flag,
		o_external_gen_enable, o_internal_gen_enable};

	// read port, data in the cycle after the strobe, zero elsewhere
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			o_rdata <= '0;
		else if (i_rd)
		begin
			unique case (i_addr)
				`ADDR_CTRL:    o_rdata <= {6'h00, external_on_bit, internal_on_bit};
				`ADDR_MULT:    o_rdata <= {1'b0, multiplier_register};
				`ADDR_STATUS:  o_rdata <= status_byte;
				`ADDR_WORD_LO: o_rdata <= osc_stage_field;
				`ADDR_WORD_HI: o_rdata <= {4'h0, osc_divider_field};
				default:       o_rdata <= '0;
			endcase
		end
		else
			o_rdata <= '0;
	end
endmodule
`default_nettype wire

// ==== tb/clkgen_sva.sv ====
// checker for the clock generator core, bound to its top-level ports
// assumes one system clock and the asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module clkgen_sva (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_stop_mode,
	input wire logic i_osc_run_in_stop_cfg,
	input wire logic i_crystal_enable_cfg,
	input wire logic o_osc_pin1_port_enable,
	input wire logic o_osc_pin2_port_enable,
	input wire logic o_generator_stop,
	input wire logic o_internal_gen_enable,
	input wire logic o_external_gen_enable,
	input wire logic o_internal_clock,
	input wire logic o_external_clock,
	input wire logic o_base_clock
);
	// all properties sample on the system clock and rest during reset
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	// stop request and run-in-stop option decide the stop signal
	stop_follow_a:
	assert property (1'b1 |=> o_generator_stop == $past(i_stop_mode && !i_osc_run_in_stop_cfg))
		else $error("stop signal does not follow stop mode");
	stop_override_a:
	assert property (i_osc_run_in_stop_cfg |=> !o_generator_stop)
		else $error("clocks stopped with run in stop set");
	// a settled stop keeps both generator enables low
	int_stop_a:
	assert property (o_generator_stop && $past(o_generator_stop) |-> !o_internal_gen_enable)
		else $error("internal enable high in stop");
	ext_stop_a:
	assert property (o_generator_stop && $past(o_generator_stop) |-> !o_external_gen_enable)
		else $error("external enable high in stop");
	// disabled generators hold their clocks low once the flops have drained
	int_quiet_a:
	assert property (!o_internal_gen_enable [*4] |-> !o_internal_clock && !o_base_clock)
		else $error("internal clock runs while disabled");
	ext_quiet_a:
	assert property (!o_external_gen_enable [*2] |-> !o_external_clock)
		else $error("external clock runs while disabled");
	// pin one stays with the oscillator while the external path is on, pin two too in crystal mode
	pin1_yield_a:
	assert property (o_external_gen_enable |-> !o_osc_pin1_port_enable)
		else $error("pin one port enabled with external clock on");
	pin2_yield_a:
	assert property (o_external_gen_enable && $past(i_crystal_enable_cfg) |-> !o_osc_pin2_port_enable)
		else $error("pin two port enabled in crystal mode");
endmodule

bind clock_generator_unit clkgen_sva chk_u (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_stop_mode(i_stop_mode),
	.i_osc_run_in_stop_cfg(i_osc_run_in_stop_cfg), .i_crystal_enable_cfg(i_crystal_enable_cfg),
	.o_osc_pin1_port_enable(o_osc_pin1_port_enable), .o_osc_pin2_port_enable(o_osc_pin2_port_enable),
	.o_generator_stop(o_generator_stop), .o_internal_gen_enable(o_internal_gen_enable),
	.o_external_gen_enable(o_external_gen_enable), .o_internal_clock(o_internal_clock),
	.o_external_clock(o_external_clock), .o_base_clock(o_base_clock)
);
`default_nettype wire

// ==== tb/ext_clock_source.sv ====
// external clock source feeding the first oscillator pin
// assumes the system clock as time base; a real source runs free, so no reset
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source #(
	parameter int HALF = 3
)(
	input  wire logic i_sys_clk,
	output logic      o_pin
);
	int   phase = 0;
	logic pin_reg = 1'b0;

	// square wave of two HALF spans, changed just after every HALF-th edge
	always @(posedge i_sys_clk)
	begin
		if (phase == HALF - 1)
		begin
			phase <= 0;
			pin_reg <= ~pin_reg;
		end
		else
			phase <= phase + 1;
	end
	assign o_pin = pin_reg;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the clock generator core
// assumes package and map header compiled first; the checker binds itself
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_map.svh"
module tb;
	import clkgen_pkg::*;
	typedef struct packed {logic wr; logic [3:0] addr; logic [7:0] data; logic [7:0] exp;} row_s;
	logic       i_sys_clk, i_rst, i_wr, i_rd, i_stop_mode, i_osc_run_in_stop_cfg;
	logic       i_external_allowed_cfg, i_crystal_enable_cfg, pin_one, int_en, ext_en;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, o_rdata, rd, lo_prev;
	logic       pin1_en, pin2_en, gen_stop, int_clk, ext_clk, base_clk, osc_clk;
	logic       gen_clk, bus_clk, tb_clk, stable;
	int         fail_count = 0;
	int         comparisons = 0;
	int         n;
	int         cnt [7];
	int         nvals [4] = '{0, 1, 3, 4};
	// register cases: reset values, unmapped place, refused external-on, multiplier
	row_s       rows [10] = '{
		'{1'b0, `ADDR_WORD_LO, 8'h00, 8'h00}, '{1'b0, `ADDR_WORD_HI, 8'h00, 8'h04},
		'{1'b0, `ADDR_CTRL, 8'h00, 8'h01}, '{1'b0, `ADDR_MULT, 8'h00, 8'h04},
		'{1'b1, 4'h7, 8'hff, 8'h00}, '{1'b0, 4'h7, 8'h00, 8'h00},
		'{1'b1, `ADDR_CTRL, 8'h03, 8'h00}, '{1'b0, `ADDR_CTRL, 8'h00, 8'h01},
		'{1'b1, `ADDR_MULT, 8'h83, 8'h00}, '{1'b0, `ADDR_MULT, 8'h00, 8'h03}};

	clock_generator_unit dut_u (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_stop_mode(i_stop_mode),
		.i_osc_run_in_stop_cfg(i_osc_run_in_stop_cfg), .i_external_allowed_cfg(i_external_allowed_cfg),
		.i_crystal_enable_cfg(i_crystal_enable_cfg), .i_osc_pin_one(pin_one),
		.o_osc_pin1_port_enable(pin1_en), .o_osc_pin2_port_enable(pin2_en), .o_generator_stop(gen_stop),
		.o_internal_gen_enable(int_en), .o_external_gen_enable(ext_en), .o_internal_clock(int_clk),
		.o_external_clock(ext_clk), .o_base_clock(base_clk), .o_osc_output_clock(osc_clk),
		.o_gen_output_clock(gen_clk), .o_bus_clock(bus_clk), .o_timebase_clock(tb_clk),
		.o_filter_stable_flag(stable)
	);
	ext_clock_source src_u (.i_sys_clk(i_sys_clk), .o_pin(pin_one));

	// compare and count
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one-cycle write and read strobes; read data taken in the cycle after
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [3:0] a);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		@(negedge i_sys_clk);
		rd = o_rdata;
	endtask

	// count rising edges of the output clocks over a span of cycles
	task automatic measure(input int span);
		logic [6:0] prev, now;
		cnt = '{default: 0};
		@(negedge i_sys_clk);
		prev = {int_clk, base_clk, ext_clk, osc_clk, gen_clk, bus_clk, tb_clk};
		repeat (span)
		begin
			@(negedge i_sys_clk);
			now = {int_clk, base_clk, ext_clk, osc_clk, gen_clk, bus_clk, tb_clk};
			for (int k = 0; k < 7; k++)
				if (now[k] && !prev[k])
					cnt[k]++;
			prev = now;
		end
	endtask

	// edge count a times ma must match b times mb within one period of b
	task automatic ratio(input int a, input int ma, input int b, input int mb);
		int diff;
		diff = cnt[a] * ma - cnt[b] * mb;
		check(12'(cnt[b] > 0 && diff <= mb + 1 && diff >= -mb - 1), 12'h001);
	endtask

	task automatic test_done;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// 25 MHz system clock
	initial
	begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	// main sequence
	initial
	begin
		i_rst = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_stop_mode = 1'b0;
		i_osc_run_in_stop_cfg = 1'b0;
		i_external_allowed_cfg = 1'b0;
		i_crystal_enable_cfg = 1'b0;
		repeat (12) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		check(12'({pin1_en, pin2_en, int_en, base_clk, o_rdata}), 12'hc00);
		check(12'({int_clk, ext_clk, ext_en, gen_stop, stable}), 12'h000);
		@(posedge i_sys_clk);
		i_rst <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i].wr)
				bus_wr(rows[i].addr, rows[i].data);
			else
			begin
				bus_rd(rows[i].addr);
				check(12'(rd), 12'(rows[i].exp));
			end
		end
		// base clock against internal clock, pass-through for zero and one
		foreach (nvals[j])
		begin
			bus_wr(`ADDR_MULT, 8'(nvals[j]));
			repeat (20) @(posedge i_sys_clk);
			measure(800);
			ratio(6, 1, 5, (nvals[j] > 1) ? nvals[j] : 1);
		end
		// external source on in crystal mode: pins yield, clocks follow it
		@(posedge i_sys_clk);
		i_external_allowed_cfg <= 1'b1;
		i_crystal_enable_cfg <= 1'b1;
		bus_wr(`ADDR_CTRL, 8'h03);
		repeat (3) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		check(12'({pin1_en, pin2_en, ext_en}), 12'h001);
		measure(480);
		ratio(0, 1, 4, 1);
		ratio(3, 1, 2, 2);
		ratio(3, 1, 1, 4);
		// stop mode halts the generators, pins stay with the oscillator
		@(posedge i_sys_clk);
		i_stop_mode <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		check(12'({gen_stop, int_en, ext_en, pin1_en, pin2_en}), 12'h010);
		measure(40);
		check(12'(cnt[6] + cnt[5] + cnt[4]), 12'h000);
		@(posedge i_sys_clk);
		i_osc_run_in_stop_cfg <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		check(12'({gen_stop, int_en, ext_en}), 12'h003);
		@(posedge i_sys_clk);
		i_stop_mode <= 1'b0;
		i_osc_run_in_stop_cfg <= 1'b0;
		bus_wr(`ADDR_CTRL, 8'h01);
		// loop filter: every word change is one allowed step until the flag rises
		bus_rd(`ADDR_WORD_LO);
		lo_prev = rd;
		n = 0;
		do
		begin
			bus_rd(`ADDR_WORD_LO);
			check(12'(8'(rd - lo_prev) inside {8'h00, 8'h01, 8'hff, 8'h08, 8'hf8, 8'h20, 8'he0}), 12'h001);
			lo_prev = rd;
			bus_rd(`ADDR_STATUS);
			n++;
		end
		while (rd[2] !== 1'b1 && n < 10000);
		check(12'(rd[2]), 12'h001);
		test_done();
	end
endmodule
`default_nettype wire
